// file: vsr_pkg.sv
// Purpose: Shared constants for the video sync restart and reprogramming block.
// Assumes: Twelve-bit timing registers on a six-bit address port.
// Notes:   Defaults give a 911-clock line and a 526-line frame.
package vsr_pkg;

  // Widths
  localparam int unsigned VSR_CW = 12;  // Register and counter width
  localparam int unsigned VSR_AW = 6;   // Address width
  localparam int unsigned VSR_NREG = 19; // Status plus eighteen data registers

  // Address map
  localparam logic [5:0] VSR_A_STATUS    = 6'h00;
  localparam logic [5:0] VSR_A_LAST_DATA = 6'h12;
  localparam logic [5:0] VSR_A_RESTART_A = 6'h16;
  localparam logic [5:0] VSR_A_RESTART_B = 6'h36;
  localparam logic [5:0] VSR_A_ZERO_A    = 6'h17;
  localparam logic [5:0] VSR_A_ZERO_B    = 6'h37;
  localparam logic [5:0] VSR_A_HCOUNT    = 6'h33;
  localparam logic [5:0] VSR_A_VCOUNT    = 6'h35;

  // Register indices used by the timing logic
  localparam int unsigned VSR_R_HFP_END    = 1;
  localparam int unsigned VSR_R_HSYNC_END  = 2;
  localparam int unsigned VSR_R_HBLANK_END = 3;
  localparam int unsigned VSR_R_HTOTAL     = 4;
  localparam int unsigned VSR_R_VFP_END    = 5;
  localparam int unsigned VSR_R_VSYNC_END  = 6;
  localparam int unsigned VSR_R_VBLANK_END = 7;
  localparam int unsigned VSR_R_VTOTAL     = 8;
  localparam int unsigned VSR_R_HDRV_START = 15;
  localparam int unsigned VSR_R_HDRV_END   = 16;
  localparam int unsigned VSR_R_VDRV_START = 17;
  localparam int unsigned VSR_R_VDRV_END   = 18;

  // Status field positions
  localparam int unsigned VSR_ST_CLKEN_BIT = 10;

  // Counter load values on clear or restart, full-range limit and zero
  localparam logic [11:0] VSR_HCNT_START = 12'h000;
  localparam logic [11:0] VSR_VCNT_START = 12'h001;
  localparam logic [11:0] VSR_CNT_MAX    = 12'hfff;
  localparam logic [11:0] VSR_ZERO       = 12'h000;

  // Built-in defaults loaded by the clear
  localparam logic [11:0] VSR_DEFAULTS [0:18] = '{
    12'h000, 12'h017, 12'h05b, 12'h09d, 12'h38e, 12'h007, 12'h00d,
    12'h029, 12'h20d, 12'h038, 12'h19a, 12'h001, 12'h013, 12'h029,
    12'h20e, 12'h38f, 12'h05c, 12'h001, 12'h015};

endpackage

// file: vsr_counter.sv
// Purpose: One twelve-bit timing counter with programmable total.
// Assumes: Step and restart come from logic on the same clock.
// Notes:   A counter that has passed its total runs on to the full range.
`timescale 1ns/1ps
`default_nettype none
module vsr_counter (
  input  wire logic        clock_in,   // Pixel clock
  input  wire logic        srst_in,    // Clear, active high
  input  wire logic        step_in,    // Advance by one
  input  wire logic        restart_in, // Reload start value
  input  wire logic [11:0] start_in,   // Value loaded on clear or restart
  input  wire logic [11:0] total_in,   // Programmed total count
  output logic      [11:0] count_out,  // Current count
  output logic             wrap_out    // Counter wraps on this step
);
  import vsr_pkg::*;

  logic [11:0] count_q;
  logic [11:0] count_d;

  // Wrap at the total, or at the full range once the total was overrun
  assign wrap_out = step_in && ((count_q == total_in) || (count_q == VSR_CNT_MAX));

  // Next count; twelve-bit arithmetic rolls over by itself
  always_comb begin
    count_d = count_q;
    if (step_in) begin
      count_d = (count_q == total_in) ? VSR_ZERO : count_q + 12'h001;
    end
  end

  // Restart overrides stepping so the count is always repositioned
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_in) begin
      count_q <= start_in;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;

endmodule
`default_nettype wire

// file: vsr_top.sv
// Purpose: Sync, blank and drive generator core with restart and live reprogramming.
// Assumes: Register port and clock share one domain; the host honours its own duties.
// Notes:   Sync, blank and drive outputs are active low; all but the two composites, ANDs of registered bits, are registered.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module vsr_top (
  input  wire logic        clock_in,     // Pixel clock, 40 MHz
  input  wire logic        srst_in,      // Clear, active high, synchronous
  input  wire logic [5:0]  addr_in,      // Register address
  input  wire logic [11:0] wdata_in,     // Write data
  input  wire logic        wr_in,        // Write strobe
  input  wire logic        rd_in,        // Read strobe
  output logic      [11:0] rdata_out,    // Read data, cycle after read strobe
  output logic             clk_en_out,   // Clock-enable status bit
  output logic             hsync_n_out,  // Horizontal sync
  output logic             vsync_n_out,  // Vertical sync
  output logic             csync_n_out,  // Composite sync
  output logic             hblank_n_out, // Horizontal blank
  output logic             vblank_n_out, // Vertical blank
  output logic             cblank_n_out, // Composite blank
  output logic             hdrive_n_out, // Horizontal drive
  output logic             vdrive_n_out  // Vertical drive
);
  import vsr_pkg::*;

  // Window test with wrap-around when start lies after end
  function automatic logic in_window(input logic [11:0] cnt, input logic [11:0] first,
                                     input logic [11:0] last);
    logic res;
    res = 1'b0;
    if (first <= last) begin
      res = (cnt >= first) && (cnt < last);
    end else begin
      res = (cnt >= first) || (cnt < last);
    end
    return res;
  endfunction

  // Register address classes
  function automatic logic is_restart(input logic [5:0] a);
    return (a == VSR_A_RESTART_A) || (a == VSR_A_RESTART_B);
  endfunction

  function automatic logic is_zero_all(input logic [5:0] a);
    return (a == VSR_A_ZERO_A) || (a == VSR_A_ZERO_B);
  endfunction

  function automatic logic is_data_reg(input logic [5:0] a);
    return a <= VSR_A_LAST_DATA;
  endfunction

  logic [11:0] regs_q [0:18];
  logic [11:0] rdata_q;
  logic        first_frame_q;
  logic        hsync_n_q;
  logic        vsync_n_q;
  logic        hblank_n_q;
  logic        vblank_n_q;
  logic        hdrive_n_q;
  logic        vdrive_n_q;
  logic        restart;
  logic        zero_all;
  logic        run;
  logic        h_wrap;
  logic        v_wrap;
  logic [11:0] hcnt;
  logic [11:0] vcnt;
  logic        hsync_d;
  logic        vsync_d;
  logic        hblank_d;
  logic        vblank_d;
  logic        hdrive_d;
  logic        vdrive_d;

  // Strobe decode; restart and zero addresses never store data
  assign restart  = wr_in && is_restart(addr_in);
  assign zero_all = wr_in && is_zero_all(addr_in);
  assign run      = regs_q[0][VSR_ST_CLKEN_BIT];
  assign clk_en_out = run;

  // Register file: clear loads defaults, restart leaves contents alone
  generate
    for (genvar i = 0; i < VSR_NREG; i++) begin : g_reg
      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          regs_q[i] <= VSR_DEFAULTS[i];
        end else if (zero_all) begin
          regs_q[i] <= VSR_ZERO;
        end else if (wr_in && is_data_reg(addr_in) && (addr_in == 6'(i))) begin
          regs_q[i] <= wdata_in;
        end
      end
    end
  endgenerate

  // Horizontal counter steps only while the clock is enabled
  vsr_counter u_hcnt (
    .clock_in   (clock_in),
    .srst_in    (srst_in),
    .step_in    (run),
    .restart_in (restart),
    .start_in   (VSR_HCNT_START),
    .total_in   (regs_q[VSR_R_HTOTAL]),
    .count_out  (hcnt),
    .wrap_out   (h_wrap)
  );

  // Vertical counter steps once per line
  vsr_counter u_vcnt (
    .clock_in   (clock_in),
    .srst_in    (srst_in),
    .step_in    (h_wrap),
    .restart_in (restart),
    .start_in   (VSR_VCNT_START),
    .total_in   (regs_q[VSR_R_VTOTAL]),
    .count_out  (vcnt),
    .wrap_out   (v_wrap)
  );

  // First frame after restart; ends when the vertical counter wraps
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      first_frame_q <= 1'b0;
    end else if (restart) begin
      first_frame_q <= 1'b1;
    end else if (v_wrap) begin
      first_frame_q <= 1'b0;
    end
  end

  // Pulse decode from the live counts and the current register values
  always_comb begin
    hsync_d  = (hcnt > regs_q[VSR_R_HFP_END]) && (hcnt <= regs_q[VSR_R_HSYNC_END]);
    vsync_d  = (vcnt > regs_q[VSR_R_VFP_END]) && (vcnt <= regs_q[VSR_R_VSYNC_END]);
    hblank_d = hcnt <= regs_q[VSR_R_HBLANK_END];
    vblank_d = vcnt <= regs_q[VSR_R_VBLANK_END];
    if (first_frame_q) begin
      // Drives begin at clock one and end as programmed
      hdrive_d = hcnt < regs_q[VSR_R_HDRV_END];
      vdrive_d = vcnt < regs_q[VSR_R_VDRV_END];
    end else begin
      hdrive_d = in_window(hcnt, regs_q[VSR_R_HDRV_START], regs_q[VSR_R_HDRV_END]);
      vdrive_d = in_window(vcnt, regs_q[VSR_R_VDRV_START], regs_q[VSR_R_VDRV_END]);
    end
  end

  // Sync and blank outputs; held while the clock is disabled
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hsync_n_q  <= 1'b1;
      vsync_n_q  <= 1'b1;
      hblank_n_q <= 1'b1;
      vblank_n_q <= 1'b1;
    end else if (run) begin
      hsync_n_q  <= ~hsync_d;
      vsync_n_q  <= ~vsync_d;
      hblank_n_q <= ~hblank_d;
      vblank_n_q <= ~vblank_d;
    end
  end

  // Drive outputs; kept separate because the first-frame decode after restart alters only these
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hdrive_n_q <= 1'b1;
      vdrive_n_q <= 1'b1;
    end else if (run) begin
      hdrive_n_q <= ~hdrive_d;
      vdrive_n_q <= ~vdrive_d;
    end
  end

  // Read port: data stand for exactly one cycle, zero otherwise
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_q <= VSR_ZERO;
    end else if (rd_in) begin
      if (is_data_reg(addr_in)) begin
        rdata_q <= regs_q[addr_in[4:0]];
      end else if (addr_in == VSR_A_HCOUNT) begin
        rdata_q <= hcnt;
      end else if (addr_in == VSR_A_VCOUNT) begin
        rdata_q <= vcnt;
      end else begin
        rdata_q <= VSR_ZERO;
      end
    end else begin
      rdata_q <= VSR_ZERO;
    end
  end

  // Composite signals follow the registered components
  assign hsync_n_out  = hsync_n_q;
  assign vsync_n_out  = vsync_n_q;
  assign csync_n_out  = hsync_n_q & vsync_n_q;
  assign hblank_n_out = hblank_n_q;
  assign vblank_n_out = vblank_n_q;
  assign cblank_n_out = hblank_n_q & vblank_n_q;
  assign hdrive_n_out = hdrive_n_q;
  assign vdrive_n_out = vdrive_n_q;
  assign rdata_out    = rdata_q;

endmodule
`default_nettype wire

// file: vsr_monitor.sv
// Purpose: Port assertions for the sync restart core.
// Assumes: One clock, synchronous clear, strobes never overlap.
// Notes:   Any register write voids the line spacing count, as totals may move.
`timescale 1ns/1ps
`default_nettype none
module vsr_monitor
  import vsr_pkg::*;
(
  input wire logic        clock_in,     // Pixel clock
  input wire logic        srst_in,      // Clear
  input wire logic [5:0]  addr_in,      // Register address
  input wire logic [11:0] wdata_in,     // Write data
  input wire logic        wr_in,        // Write strobe
  input wire logic        rd_in,        // Read strobe
  input wire logic [11:0] rdata_out,    // Read data
  input wire logic        clk_en_out,   // Enable bit
  input wire logic        hsync_n_out,  // Line sync
  input wire logic        hdrive_n_out, // Line drive
  input wire logic        vdrive_n_out  // Field drive
);
  logic [11:0] htot_q;
  logic [11:0] gap_q;
  logic        hs_q;
  logic        ok_q;
  logic        rs_w;
  default clocking cb @(posedge clock_in); endclocking
  assign rs_w = wr_in && (addr_in == VSR_A_RESTART_A || addr_in == VSR_A_RESTART_B);
  // Shadow line total and cycles between sync falls
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      htot_q <= VSR_DEFAULTS[4];
    end else if (wr_in && addr_in == 6'h04) begin
      htot_q <= wdata_in;
    end
    hs_q  <= hsync_n_out;
    gap_q <= (hs_q && !hsync_n_out) ? 12'h000 : gap_q + 12'h001;
    ok_q  <= !(srst_in || wr_in || !clk_en_out) && (ok_q || (hs_q && !hsync_n_out));
  end
  a_reset_defaults: assert property (disable iff (srst_in) $fell(srst_in) |->
    !clk_en_out && rdata_out == 12'h000 && hsync_n_out && hdrive_n_out && vdrive_n_out)
    else $error("outputs not at clear values");
  a_hold_disabled: assert property (disable iff (srst_in) !clk_en_out && !wr_in |=>
    $stable({hsync_n_out, hdrive_n_out, vdrive_n_out})) else $error("outputs moved while disabled");
  a_enable_write: assert property (disable iff (srst_in) wr_in && addr_in == VSR_A_STATUS |=>
    clk_en_out == $past(wdata_in[10])) else $error("enable bit not taken from write");
  a_read_idle: assert property (disable iff (srst_in) !rd_in |=> rdata_out == 12'h000)
    else $error("read data outside read slot");
  a_status_read: assert property (disable iff (srst_in) rd_in && addr_in == VSR_A_STATUS |=>
    rdata_out[10] == clk_en_out) else $error("status read disagrees with enable");
  a_restart_drive: assert property (disable iff (srst_in) rs_w && clk_en_out |->
    ##[1:4] (!hdrive_n_out && !vdrive_n_out)) else $error("drives not low after restart");
  a_restart_count: assert property (disable iff (srst_in) rs_w && clk_en_out ##1 !wr_in ##1
    (rd_in && addr_in == VSR_A_HCOUNT) |=> rdata_out == VSR_HCNT_START + 12'h001)
    else $error("line count not restarted");
  a_line_length: assert property (disable iff (srst_in) hs_q && !hsync_n_out && ok_q |->
    gap_q == htot_q) else $error("line length differs from total");
endmodule
bind vsr_top vsr_monitor mon_u (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .clk_en_out(clk_en_out),
  .hsync_n_out(hsync_n_out), .hdrive_n_out(hdrive_n_out), .vdrive_n_out(vdrive_n_out));
`default_nettype wire

// file: vsr_host.sv
// Purpose: Host controller model that loads the timing registers.
// Assumes: Tasks are entered just after a rising edge.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module vsr_host (
  input  wire logic        clock_in,  // Pixel clock
  input  wire logic [11:0] rdata_in,  // Read data from the core
  output logic      [5:0]  addr_out,  // Register address
  output logic      [11:0] wdata_out, // Write data
  output logic             wr_out,    // Write strobe
  output logic             rd_out     // Read strobe
);
  // Idle bus at time zero
  initial begin
    addr_out = 6'h00;
    wdata_out = 12'h000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write; released lines flip so stale values never look valid
  // An idle cycle follows, so a following task never reassigns a line in the same step
  task automatic put(input logic [5:0] a, input logic [11:0] d);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clock_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
    @(posedge clock_in);
  endtask
  // Read data stand only in the cycle after the strobe; taken at the edge ending it
  task automatic get(input logic [5:0] a, output logic [11:0] d);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clock_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(posedge clock_in);
    d = rdata_in;
  endtask
  // Counting needs the enable bit even with default timing
  task automatic start_clock();
    put(6'h00, 12'h400);
  endtask
  // Reprogramming ends with a restart so no counter overruns
  task automatic restart(input logic [5:0] a);
    put(a, 12'h000);
  endtask
endmodule
`default_nettype wire

// file: video_sync_restart_reprogram_tb.sv
// Purpose: Self-checking bench for the sync restart core.
// Assumes: Host model drives the register port.
// Notes:   Runs about eight thousand three hundred clocks.
`timescale 1ns/1ps
`default_nettype none
module video_sync_restart_reprogram_tb;
  import vsr_pkg::*;
  logic        clock_in = 1'b0;
  logic        srst_in  = 1'b1;
  logic [5:0]  addr;
  logic [5:0]  a;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic [11:0] d;
  logic        wr;
  logic        rd;
  logic        clk_en;
  logic        hs_n;
  logic        hd_n;
  logic        vd_n;
  logic        vs_n;
  logic        cs_n;
  logic        hb_n;
  logic        vb_n;
  logic        cb_n;
  logic [31:0] lfsr;
  int          err_count = 0;
  int          n_checks  = 0;

  always #12.5 clock_in = ~clock_in;
  vsr_top dut_u (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .clk_en_out(clk_en), .hsync_n_out(hs_n),
    .vsync_n_out(vs_n), .csync_n_out(cs_n), .hblank_n_out(hb_n), .vblank_n_out(vb_n), .cblank_n_out(cb_n),
    .hdrive_n_out(hd_n), .vdrive_n_out(vd_n));
  vsr_host host_u (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));

  // Comparisons
  task automatic chk12(input string n, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rdc(input logic [5:0] ra, input logic [11:0] e);
    host_u.get(ra, d);
    chk12($sformatf("register %h", ra), e, d);
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Counter model: wrap at the total, or at the top once past it
  function automatic logic [11:0] cnt(input logic [11:0] c, input int n, input logic [11:0] t);
    logic [11:0] v;
    v = c;
    for (int i = 0; i < n; i++) v = (v == t || v == 12'hfff) ? 12'h000 : v + 12'h001;
    return v;
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    nap(20000);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    lfsr = 32'h2ea63446;
    nap(4);
    srst_in <= 1'b0;
    for (int i = 0; i < 19; i++) rdc(6'(i), VSR_DEFAULTS[i]);
    rdc(6'h14, 12'h000);
    rdc(VSR_A_HCOUNT, 12'h000);
    nap(50);
    rdc(VSR_A_HCOUNT, 12'h000);
    for (int i = 0; i < 8; i++) begin
      lfsr = nx(lfsr);
      a = 6'h09 + 6'(lfsr[7:0] % 6);
      host_u.put(a, lfsr[27:16]);
      rdc(a, lfsr[27:16]);
    end
    host_u.put(6'h13, 12'hfff);
    rdc(6'h13, 12'h000);
    host_u.start_clock();
    chk1("enable bit", 1'b1, clk_en);
    host_u.restart(VSR_A_RESTART_A);
    rdc(VSR_A_HCOUNT, VSR_HCNT_START + 12'h001);
    rdc(VSR_A_VCOUNT, VSR_VCNT_START);
    @(negedge clock_in);
    chk1("line drive", 1'b0, hd_n);
    chk1("field drive", 1'b0, vd_n);
    @(posedge clock_in);
    // Deep in the first line: line sync low, field sync high, composite follows both
    nap(40);
    @(negedge clock_in);
    chk1("line sync", 1'b0, hs_n);
    chk1("field sync", 1'b1, vs_n);
    chk1("composite sync", 1'b0, cs_n);
    chk1("line drive", 1'b0, hd_n);
    @(posedge clock_in);
    // Lower the line total far below the running count
    host_u.restart(VSR_A_RESTART_B);
    nap(500);
    host_u.put(6'h04, 12'h064);
    nap(3000);
    rdc(VSR_A_HCOUNT, cnt(12'd502, 3001, 12'h064));
    nap(600);
    rdc(VSR_A_HCOUNT, cnt(12'd502, 3603, 12'h064));
    // Short frame with a narrow field drive window; line total rewritten in blanking
    while (hb_n !== 1'b0) @(posedge clock_in);
    host_u.put(6'h04, 12'h38e);
    host_u.put(6'h08, 12'h003);
    host_u.put(6'h11, 12'h002);
    host_u.put(6'h12, 12'h003);
    host_u.restart(VSR_A_RESTART_A);
    rdc(6'h04, 12'h38e);
    nap(498);
    @(negedge clock_in);
    chk1("field drive", 1'b0, vd_n);
    chk1("line blank", 1'b1, hb_n);
    chk1("field blank", 1'b0, vb_n);
    chk1("composite blank", 1'b0, cb_n);
    @(posedge clock_in);
    nap(3499);
    @(negedge clock_in);
    chk1("field drive", 1'b1, vd_n);
    @(posedge clock_in);
    srst_in <= 1'b1;
    nap(2);
    srst_in <= 1'b0;
    rdc(6'h08, VSR_DEFAULTS[8]);
    chk1("enable bit", 1'b0, clk_en);
    // The clear address, unlike the restart addresses, wipes the registers
    host_u.put(VSR_A_ZERO_B, 12'hfff);
    rdc(6'h08, 12'h000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
